// ---- rtl/pfs_consts.svh ----
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// ----------------------------------------
// Wishbone register byte offsets
// ----------------------------------------
`define PFS_ADR_CTRL 8'h00
`define PFS_ADR_STATUS 8'h04
`define PFS_ADR_FAULT 8'h08
`define PFS_ADR_T_START 8'h10
`define PFS_ADR_T_RUN 8'h14
`define PFS_ADR_T_DISS 8'h18
`define PFS_ADR_T_EARLY 8'h1C
`define PFS_ADR_T_CMDCHG 8'h20
`define PFS_ADR_T_COVC 8'h24
`define PFS_ADR_T_BOVC 8'h28
`define PFS_ADR_T_OVLP 8'h2C
`define PFS_ADR_T_CLONG 8'h30
`define PFS_ADR_T_BLONG 8'h34
`define PFS_ADR_T_CCOOL 8'h38
`define PFS_ADR_T_BCOOL 8'h3C
`define PFS_ADR_T_BRKOPN 8'h40
`define PFS_ADR_T_COMM 8'h44
`define PFS_ADR_T_USPD 8'h48
`define PFS_ADR_LIM_CUR 8'h4C
`define PFS_ADR_PCT 8'h50
`define PFS_ADR_ANG 8'h54
`define PFS_ADR_SPD 8'h58
`define PFS_ADR_LATCH 8'h5C

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PFS_CTRL_ENABLE_BIT 0
`define PFS_TIME_RST 32'h0000_03E8
`define PFS_LIMIT_RST 16'h0FFF
`define PFS_OVLP_PCT 16'h0014
`define PFS_PCT_RST 16'h0050
`define PFS_ANG_RST 32'h0DF2_0BB8
`define PFS_TOL_RST 16'h0014
`define PFS_SPD_RST 16'h0190

// ----------------------------------------
// Fault codes (decimal numbers held in hex)
// ----------------------------------------
`define PFS_F218 16'h00DA
`define PFS_F219 16'h00DB
`define PFS_F223 16'h00DF
`define PFS_F224 16'h00E0
`define PFS_F225 16'h00E1
`define PFS_F226 16'h00E2
`define PFS_F227 16'h00E3
`define PFS_F228 16'h00E4
`define PFS_F229 16'h00E5
`define PFS_F231 16'h00E7
`define PFS_F313 16'h0139
`define PFS_F314 16'h013A
`define PFS_F315 16'h013B
`define PFS_F316 16'h013C
`define PFS_F317 16'h013D
`define PFS_F318 16'h013E
`define PFS_F319 16'h013F
`define PFS_F320 16'h0140
`define PFS_F321 16'h0141
`define PFS_NFAULT 19

`endif

// ---- rtl/pfs_pkg.sv ----
package pfs_pkg;
    typedef struct packed {
        logic en_low;
        logic en_high;
        logic clutch_on;
        logic inch;
        logic micro_inch;
        logic reverse;
        logic clutch_cont;
        logic brake_cont;
        logic run_mode;
        logic single_stroke;
        logic stop_on_top;
        logic fault_reset;
        logic status_upd;
    } pfs_din_s;

    typedef struct packed {
        logic [15:0] clutch_cur;
        logic [15:0] brake_cur;
        logic [15:0] speed;
        logic [15:0] speed_sp;
        logic [15:0] angle;
        logic at_rest;
    } pfs_meas_s;

    typedef enum logic [1:0] {
        PFS_IDLE = 2'b00,
        PFS_START = 2'b01,
        PFS_RUN = 2'b10,
        PFS_STOP = 2'b11
    } pfs_phase_e;
endpackage : pfs_pkg

// ---- rtl/pfs_timer.sv ----
`timescale 1ns/1ps
// Times a condition in ms ticks; restarts when the condition drops.
module pfs_timer #(
    parameter int W = 32
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic cond_i,
    input wire logic [W-1:0] limit_i,
    output logic expired_o
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !cond_i) begin
            cnt_r <= '0;
        end else if (tick_i && cnt_r < limit_i) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign expired_o = cond_i && (cnt_r >= limit_i);
endmodule : pfs_timer

// ---- rtl/pfs_wb_slave.sv ----
`timescale 1ns/1ps
`include "pfs_consts.svh"
// Classic Wishbone slave: registered ack, one wait state, no bursts.
module pfs_wb_slave (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wr_o,
    output logic [7:0] adr_o,
    output logic [31:0] wdat_o,
    input wire logic [31:0] rdat_i
);
    logic [31:0] mask;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            mask[i*8 +: 8] = {8{wb_sel_i[i]}};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
                wb_dat_o <= rdat_i;
            end
        end
    end

    // Write lands on the same edge the ack is sampled by the master
    assign wr_o = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign adr_o = wb_adr_i;
    assign wdat_o = (wb_dat_i & mask) | (rdat_i & ~mask);
endmodule : pfs_wb_slave

// ---- rtl/pfs_supervisor.sv ----
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pfs_consts.svh"

// Contract
// - Both enables, clutch-on, contactor open past start/run limit sets 218.
// - Any enable closed at power-up or fault reset sets 219.
// - Contactor still closed after dissipation delay while stopping sets 223.
// - Contactor opening before minimum delay while stopping sets 225.
// - Single stroke rest outside stop angle tolerance sets 224.
// - Creep speed past creep angle; not reached at stop angle sets 226.
// - Enable during clutch cool-down after clutch current fault sets 227.
// - Enable during brake cool-down after brake current fault sets 228.
// - Brake contactor open for programmed time sets 229.
// - No status update within timeout sets 231.
// - Speed under set point by percentage for trip time sets 313.
// - Both currents above 20 percent of max for overlap time sets 314.
// - Clutch current above max for programmed time sets 315.
// - Brake current above max for programmed time sets 316.
// - Inch, micro-inch, reverse change in run mode sets 317, 318, 319.
// - Clutch or brake current above own percent for own time sets 320/321.
// - Three-hundred faults request stop on top.
// - Two-hundred faults request stop now.
module pfs_supervisor
    import pfs_pkg::*;
#(
    parameter int TICK_DIV = 100000
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire pfs_din_s din_i,
    input wire pfs_meas_s meas_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic stop_now_o,
    output logic stop_on_top_o,
    output logic creep_cmd_o,
    output logic [15:0] fault_code_o
);
    localparam int NT = 16;
    localparam int NF = `PFS_NFAULT;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    pfs_din_s din_s1_r, din_r;
    pfs_meas_s meas_s1_r, meas_r;

    always_ff @(posedge sys_clk_i) begin
        din_s1_r <= din_i;
        din_r <= din_s1_r;
        meas_s1_r <= meas_i;
        meas_r <= meas_s1_r;
    end

    // ----------------------------------------
    // Millisecond tick
    // ----------------------------------------
    logic [31:0] div_r;
    logic tick;

    assign tick = (div_r == 32'(TICK_DIV - 1));

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0] time_r [NT];
    logic [15:0] lim_clutch_r, lim_brake_r;
    logic [15:0] pct_clutch_r, pct_brake_r, pct_under_r, tol_r;
    logic [15:0] creep_ang_r, stop_ang_r, creep_spd_r;
    logic sup_en_r;
    logic [NF-1:0] latch_r;
    logic [15:0] code_r;
    logic [1:0] phase;
    logic stop_done;
    logic wr;
    logic [7:0] adr;
    logic [31:0] wdat, rdat;

    pfs_wb_slave u_wb (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .wr_o(wr),
        .adr_o(adr),
        .wdat_o(wdat),
        .rdat_i(rdat)
    );

    // Timer slots follow the time register offsets 0x10..0x48 in order
    function automatic logic is_time(input logic [7:0] a);
        return a >= `PFS_ADR_T_START && a <= `PFS_ADR_T_USPD && a[1:0] == 2'b00;
    endfunction : is_time

    function automatic logic [3:0] time_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - `PFS_ADR_T_START;
        return d[5:2];
    endfunction : time_idx

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NT; i++) begin
                time_r[i] <= `PFS_TIME_RST;
            end
        end else if (wr && is_time(adr)) begin
            time_r[time_idx(adr)] <= wdat;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sup_en_r <= 1'b1;
            lim_clutch_r <= `PFS_LIMIT_RST;
            lim_brake_r <= `PFS_LIMIT_RST;
            pct_clutch_r <= `PFS_PCT_RST;
            pct_brake_r <= `PFS_PCT_RST;
            pct_under_r <= `PFS_TOL_RST;
            tol_r <= `PFS_TOL_RST;
            {stop_ang_r, creep_ang_r} <= `PFS_ANG_RST;
            creep_spd_r <= `PFS_SPD_RST;
        end else if (wr) begin
            unique case (adr)
                `PFS_ADR_CTRL: sup_en_r <= wdat[`PFS_CTRL_ENABLE_BIT];
                `PFS_ADR_LIM_CUR: {lim_brake_r, lim_clutch_r} <= wdat;
                `PFS_ADR_PCT: {pct_brake_r, pct_clutch_r} <= wdat;
                `PFS_ADR_ANG: {stop_ang_r, creep_ang_r} <= wdat;
                `PFS_ADR_SPD: {tol_r, creep_spd_r} <= wdat;
                `PFS_ADR_T_USPD + 8'h20: pct_under_r <= wdat[15:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rdat = 32'h0000_0000;
        if (is_time(adr)) begin
            rdat = time_r[time_idx(adr)];
        end else begin
            unique case (adr)
                `PFS_ADR_CTRL: rdat = {31'h0, sup_en_r};
                `PFS_ADR_STATUS: rdat = {28'h0, creep_cmd_o, phase, stop_now_o};
                `PFS_ADR_FAULT: rdat = {16'h0, code_r};
                `PFS_ADR_LATCH: rdat = 32'(latch_r);
                `PFS_ADR_LIM_CUR: rdat = {lim_brake_r, lim_clutch_r};
                `PFS_ADR_PCT: rdat = {pct_brake_r, pct_clutch_r};
                `PFS_ADR_ANG: rdat = {stop_ang_r, creep_ang_r};
                `PFS_ADR_SPD: rdat = {tol_r, creep_spd_r};
                `PFS_ADR_T_USPD + 8'h20: rdat = {16'h0, pct_under_r};
                default: rdat = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Operating phase
    // ----------------------------------------
    pfs_phase_e phase_r;
    logic both_en, any_en, cl_on;

    assign phase = phase_r;
    assign both_en = din_r.en_low && din_r.en_high;
    assign any_en = din_r.en_low || din_r.en_high;
    assign cl_on = both_en && din_r.clutch_on;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            phase_r <= PFS_IDLE;
        end else begin
            unique case (phase_r)
                PFS_IDLE: if (cl_on) phase_r <= PFS_START;
                PFS_START: if (!cl_on) phase_r <= PFS_STOP;
                    else if (din_r.clutch_cont) phase_r <= PFS_RUN;
                PFS_RUN: if (!cl_on) phase_r <= PFS_STOP;
                PFS_STOP: if (cl_on) phase_r <= PFS_START;
                    else if (!din_r.clutch_cont && stop_done) phase_r <= PFS_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Conditions and timers
    // ----------------------------------------
    logic [NT-1:0] cond, exp_t;
    logic [15:0] lim_c20, lim_b20, lim_cp, lim_bp, sp_margin;
    logic [2:0] mode_now, mode_prev_r;
    logic cc_cool, bc_cool, stopping;

    function automatic logic [15:0] pct_of(input logic [15:0] v, input logic [15:0] p);
        logic [31:0] prod;
        prod = v * p;
        return 16'(prod / 32'd100);
    endfunction : pct_of

    assign lim_c20 = pct_of(lim_clutch_r, `PFS_OVLP_PCT);
    assign lim_b20 = pct_of(lim_brake_r, `PFS_OVLP_PCT);
    assign lim_cp = pct_of(lim_clutch_r, pct_clutch_r);
    assign lim_bp = pct_of(lim_brake_r, pct_brake_r);
    assign sp_margin = pct_of(16'hFFFF, pct_under_r);
    assign stopping = (phase_r == PFS_STOP);
    assign stop_done = exp_t[3];

    assign mode_now = {din_r.inch, din_r.micro_inch, din_r.reverse};

    always_ff @(posedge sys_clk_i) begin
        mode_prev_r <= mode_now;
    end

    // Run-mode command change is held as a level until the bit changes back or run mode drops
    logic [2:0] chg_r;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !din_r.run_mode) begin
            chg_r <= 3'b000;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (mode_prev_r[i] != mode_now[i]) begin
                    chg_r[i] <= !chg_r[i];
                end
            end
        end
    end

    always_comb begin
        cond = '0;
        cond[0] = cl_on && !din_r.clutch_cont && phase_r == PFS_START;
        cond[1] = cl_on && !din_r.clutch_cont && phase_r == PFS_RUN;
        cond[2] = stopping && din_r.clutch_cont;
        cond[3] = stopping;
        cond[4] = |chg_r;
        cond[5] = meas_r.clutch_cur > lim_clutch_r;
        cond[6] = meas_r.brake_cur > lim_brake_r;
        cond[7] = meas_r.clutch_cur > lim_c20 && meas_r.brake_cur > lim_b20;
        cond[8] = meas_r.clutch_cur > lim_cp;
        cond[9] = meas_r.brake_cur > lim_bp;
        cond[10] = cc_cool;
        cond[11] = bc_cool;
        cond[12] = !din_r.brake_cont;
        cond[13] = !din_r.status_upd;
        // under speed
        // Summed in 17 bits so a speed plus margin above 16 bits cannot wrap
        cond[14] = phase_r == PFS_RUN
                   && 17'(meas_r.speed) + 17'(sp_margin) < 17'(meas_r.speed_sp);
    end

    genvar g;
    generate
        for (g = 0; g < NT; g++) begin : g_tmr
            pfs_timer #(.W(32)) u_t (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i && sup_en_r),
                .tick_i(tick),
                .cond_i(cond[g]),
                .limit_i(time_r[g]),
                .expired_o(exp_t[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Cool-down and creep
    // ----------------------------------------
    logic first_r, rst_prev_r, creep_r, at_top_prev_r;
    logic [15:0] dang;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cc_cool <= 1'b0;
            bc_cool <= 1'b0;
        end else begin
            if (exp_t[5] || exp_t[8]) cc_cool <= 1'b1;
            else if (exp_t[10]) cc_cool <= 1'b0;
            if (exp_t[6] || exp_t[9]) bc_cool <= 1'b1;
            else if (exp_t[11]) bc_cool <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !din_r.single_stroke || phase_r == PFS_IDLE) begin
            creep_r <= 1'b0;
        end else if (din_r.stop_on_top && meas_r.angle >= creep_ang_r) begin
            creep_r <= 1'b1;
        end
    end
    assign creep_cmd_o = creep_r;

    assign dang = meas_r.angle > stop_ang_r ? meas_r.angle - stop_ang_r
                                            : stop_ang_r - meas_r.angle;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            first_r <= 1'b1;
            rst_prev_r <= 1'b0;
            at_top_prev_r <= 1'b0;
        end else begin
            first_r <= 1'b0;
            rst_prev_r <= din_r.fault_reset;
            at_top_prev_r <= meas_r.at_rest;
        end
    end

    // ----------------------------------------
    // Fault latch
    // ----------------------------------------
    logic [NF-1:0] hit;
    logic [15:0] codes [NF];
    logic rst_edge;

    assign rst_edge = din_r.fault_reset && !rst_prev_r;
    assign codes = '{`PFS_F218, `PFS_F218, `PFS_F223, `PFS_F225, `PFS_F219,
                     `PFS_F224, `PFS_F226, `PFS_F227, `PFS_F228, `PFS_F229,
                     `PFS_F231, `PFS_F313, `PFS_F314, `PFS_F315, `PFS_F316,
                     `PFS_F317, `PFS_F318, `PFS_F319, `PFS_F320};

    always_comb begin
        hit = '0;
        hit[0] = exp_t[0] || exp_t[1];
        hit[2] = exp_t[2];
        hit[3] = stopping && !din_r.clutch_cont && !exp_t[3];
        hit[4] = (first_r || rst_edge) && any_en;
        hit[5] = din_r.single_stroke && meas_r.at_rest && !at_top_prev_r
                 && creep_r && dang > tol_r;
        hit[6] = creep_r && meas_r.angle >= stop_ang_r && meas_r.speed > creep_spd_r;
        hit[7] = cc_cool && any_en;
        hit[8] = bc_cool && any_en;
        hit[9] = exp_t[12];
        hit[10] = exp_t[13];
        hit[11] = exp_t[14];
        hit[12] = exp_t[7];
        hit[13] = exp_t[5];
        hit[14] = exp_t[6];
        hit[15] = exp_t[4] && chg_r[2];
        hit[16] = exp_t[4] && chg_r[1];
        hit[17] = exp_t[4] && chg_r[0];
        hit[18] = exp_t[8] || exp_t[9];
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            latch_r <= '0;
        end else begin
            latch_r <= (rst_edge ? '0 : latch_r) | (sup_en_r ? hit : '0);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            code_r <= 16'h0000;
        end else if (sup_en_r && |hit) begin
            for (int i = 0; i < NF; i++) begin
                if (hit[i]) begin
                    code_r <= (i == 18 && exp_t[9]) ? `PFS_F321 : codes[i];
                end
            end
        end else if (rst_edge) begin
            code_r <= 16'h0000;
        end
    end
    assign fault_code_o = code_r;

    assign stop_now_o = |latch_r[10:0];
    assign stop_on_top_o = |latch_r[NF-1:11];
endmodule : pfs_supervisor

// ---- testbench/pfs_press_model.sv ----
`timescale 1ns/1ps
module pfs_press_model
    import pfs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire pfs_din_s cmd_i,
    input wire logic fr_req_i,
    output pfs_din_s din_o
);
    logic [2:0] fr_cnt_r = 3'h0;

    // fault reset pulse
    // Held several cycles so the two-flop input stage cannot miss it
    always_ff @(posedge sys_clk_i) begin
        if (fr_req_i) begin
            fr_cnt_r <= 3'h4;
        end else if (fr_cnt_r != 3'h0) begin
            fr_cnt_r <= fr_cnt_r - 3'h1;
        end
    end

    // mode bits only move on command
    always_comb begin
        din_o = cmd_i;
        din_o.fault_reset = (fr_cnt_r != 3'h0);
    end
endmodule : pfs_press_model

// ---- testbench/pfs_supervisor_asserts.sv ----
`timescale 1ns/1ps
module pfs_supervisor_asserts
    import pfs_pkg::*;
#(
    parameter int TICK_DIV = 100000
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire pfs_din_s din_i,
    input wire pfs_meas_s meas_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic stop_now_o,
    input wire logic stop_on_top_o,
    input wire logic creep_cmd_o,
    input wire logic [15:0] fault_code_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [3:0] fr_age_r;

    // Cycles since fault reset was last seen; a latch may only drop soon after it
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || din_i.fault_reset) begin
            fr_age_r <= {4{!rst_n_i}};
        end else if (fr_age_r != 4'hF) begin
            fr_age_r <= fr_age_r + 4'h1;
        end
    end

    a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    a_now_latched: assert property ($fell(stop_now_o) |-> fr_age_r < 4'h8)
        else $error("stop now dropped without fault reset");
    a_top_latched: assert property ($fell(stop_on_top_o) |-> fr_age_r < 4'h8)
        else $error("stop on top dropped without fault reset");
    a_now_class: assert property ($rose(stop_now_o) |-> ##[0:2]
        (fault_code_o >= 16'h00C8 && fault_code_o < 16'h012C))
        else $error("stop now without two-hundred code");
    a_top_class: assert property ($rose(stop_on_top_o) |-> ##[0:2]
        (fault_code_o >= 16'h012C && fault_code_o < 16'h0190))
        else $error("stop on top without three-hundred code");
    a_reset_quiet: assert property ($rose(rst_n_i) |->
        !stop_now_o && !stop_on_top_o && fault_code_o == 16'h0000)
        else $error("outputs not clear after reset");

    c_now: cover property ($rose(stop_now_o));
    c_top: cover property ($rose(stop_on_top_o));
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule : pfs_supervisor_asserts

bind pfs_supervisor pfs_supervisor_asserts #(.TICK_DIV(TICK_DIV)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .din_i(din_i), .meas_i(meas_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .stop_now_o(stop_now_o), .stop_on_top_o(stop_on_top_o),
    .creep_cmd_o(creep_cmd_o), .fault_code_o(fault_code_o)
);

// ---- testbench/pfs_supervisor_test.sv ----
`timescale 1ns/1ps
`include "pfs_consts.svh"
module pfs_supervisor_test import pfs_pkg::*;;
    typedef struct packed {
        pfs_din_s din;
        logic [15:0] cur_c;
        logic [15:0] cur_b;
        logic [15:0] sp;
        logic [15:0] code;
        logic [7:0] wt;
    } pfs_row_s;
    logic clk, rst_n, cyc, stb, we, fr_req, ack, s_now, s_top;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [15:0] code;
    pfs_din_s cmd, din;
    pfs_meas_s meas;
    pfs_row_s rows[9];
    int miscompares, checks;

    pfs_press_model i_press (.sys_clk_i(clk), .cmd_i(cmd), .fr_req_i(fr_req), .din_o(din));
    pfs_supervisor #(.TICK_DIV(10)) i_dut (
        .sys_clk_i(clk), .rst_n_i(rst_n), .din_i(din), .meas_i(meas),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .stop_now_o(s_now), .stop_on_top_o(s_top), .creep_cmd_o(), .fault_code_o(code)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (n >= 16) cmp_flag("ack", 1'b1, ack);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_val

    task automatic cmp_flag(input string nm, input logic e, input logic g);
        cmp_val(nm, {31'h0, e}, {31'h0, g});
    endtask : cmp_flag

    // Quiet inputs settle through the input stage before the reset pulse
    task automatic clear(input pfs_din_s d);
        cmd <= d;
        meas <= '0;
        step(6);
        fr_req <= 1'b1;
        step(1);
        fr_req <= 1'b0;
        step(10);
    endtask : clear

    task automatic apply(input pfs_row_s r);
        cmd <= r.din;
        meas <= {r.cur_c, r.cur_b, 16'h0000, r.sp, 16'h0000, 1'b0};
        step(int'(r.wt));
        cmp_val("fault_code", {16'h0000, r.code}, {16'h0000, code});
        cmp_flag("stop_now", r.code < 16'h012C, s_now);
        cmp_flag("stop_on_top", r.code >= 16'h012C, s_top);
    endtask : apply

    task automatic summarize();
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    initial begin
        step(20000);
        miscompares++;
        summarize();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        cmd = 13'h0021;
        meas = '0;
        fr_req = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0000_0000;
        miscompares = 0;
        checks = 0;
        rows = '{
            // Running row first, before any cool-down could refuse the enables
            '{13'h1C61, 16'h0000, 16'h0000, 16'h8000, `PFS_F313, 8'h50},
            '{13'h1C21, 16'h0000, 16'h0000, 16'h0000, `PFS_F218, 8'h50},
            '{13'h0001, 16'h0000, 16'h0000, 16'h0000, `PFS_F229, 8'h50},
            '{13'h0020, 16'h0000, 16'h0000, 16'h0000, `PFS_F231, 8'h50},
            '{13'h0021, 16'hF000, 16'h0000, 16'h0000, `PFS_F315, 8'h28},
            '{13'h0021, 16'h0000, 16'hF000, 16'h0000, `PFS_F316, 8'h28},
            '{13'h0021, 16'h0600, 16'h0600, 16'h0000, `PFS_F314, 8'h50},
            '{13'h0021, 16'h0E00, 16'h0000, 16'h0000, `PFS_F320, 8'h78},
            '{13'h0021, 16'h0000, 16'h0E00, 16'h0000, `PFS_F321, 8'h78}
        };
        step(10);
        rst_n <= 1'b1;
        wb(1'b0, `PFS_ADR_T_START, 32'h0000_0000);
        cmp_val("t_start", `PFS_TIME_RST, q);
        wb(1'b0, 8'hFC, 32'h0000_0000);
        cmp_val("unmapped", 32'h0000_0000, q);
        wb(1'b1, `PFS_ADR_CTRL, 32'h0000_0001);
        // Over-current one tick, on-too-long and cool-down eight, the rest three
        for (int k = 0; k < 15; k++) begin
            wb(1'b1, 8'h10 + 8'(4 * k), (k == 5 || k == 6) ? 32'h0000_0001 :
                (k >= 8 && k <= 11) ? 32'h0000_0008 : 32'h0000_0003);
        end
        wb(1'b0, `PFS_ADR_T_COVC, 32'h0000_0000);
        cmp_val("t_covc", 32'h0000_0001, q);
        foreach (rows[i]) begin
            clear(13'h0021);
            apply(rows[i]);
        end
        for (int i = 0; i < 2; i++) begin
            clear(13'h0021);
            apply(rows[4 + i]);
            clear(13'h0021);
            cmd <= 13'h1821;
            step(40);
            cmp_val("cool_down", {16'h0000, `PFS_F227 + 16'(i)}, {16'h0000, code});
        end
        for (int i = 0; i < 3; i++) begin
            clear(13'h0031);
            cmd <= 13'h0031 | (13'h0200 >> i);
            step(80);
            cmp_val("mode_change", {16'h0000, `PFS_F317 + 16'(i)}, {16'h0000, code});
        end
        // Brake opens shorter than its limit each time: the timer must restart
        repeat (3) begin
            cmd <= 13'h0011;
            step(15);
            cmd <= 13'h0031;
            step(15);
        end
        cmp_flag("stop_now", 1'b0, s_now);
        cmp_flag("stop_on_top", 1'b1, s_top);
        clear(13'h1021);
        step(20);
        cmp_val("enable_at_reset", {16'h0000, `PFS_F219}, {16'h0000, code});
        rst_n <= 1'b0;
        step(5);
        rst_n <= 1'b1;
        step(20);
        cmp_val("enable_at_start", {16'h0000, `PFS_F219}, {16'h0000, code});
        cmp_flag("stop_now", 1'b1, s_now);
        summarize();
    end
endmodule : pfs_supervisor_test
